//--- core/dcmc_pkg.sv
// Purpose: shared constants and types for the dma channel mode control block
// Assumes: apb register bus, single clock mclk, 16-bit mode register in low half of word
// Notes: How it works list follows
// How it works
// - bit 10 picks dual (0) or single (1) addressing
// - acknowledge pin driven only in single addressing
// - two bits pick one of four transfer modes
// - channel interrupt when enable and flag both set
// - channel interrupt drops when enable or flag clears
// - flag set by count end or repeat overflow
// - flag setting also ends the channel transfer
// - writing one to active bit clears flag
// - flag cleared by writing zero after reading one
// - count end sets flag only when enabled
// - single addressing direction bit picks data path
// - dual addressing ignores the direction bit
// - external request: level or falling edge sensing
// - clear-only irq flag accepts only zero writes
package dcmc_pkg;

  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned MODE_W = 16;
  localparam int unsigned EV_W = 4;

  localparam logic [ADDR_W-1:0] MODE_OFS = 12'h000;
  localparam logic [ADDR_W-1:0] STAT_OFS = 12'h004;
  localparam logic [ADDR_W-1:0] MASK_OFS = 12'h008;

  localparam int unsigned BIT_ACTIVE = 15;
  localparam int unsigned BIT_REQ_SENSE = 11;
  localparam int unsigned BIT_AMS = 10;
  localparam int unsigned BIT_MODE_HI = 9;
  localparam int unsigned BIT_MODE_LO = 8;
  localparam int unsigned BIT_IRQ_EN = 7;
  localparam int unsigned BIT_IRQ_FLAG = 6;
  localparam int unsigned BIT_TCE_EN = 5;
  localparam int unsigned BIT_SINGLE_ADDR_DIRECTION = 4;

  localparam int unsigned EV_COUNT_END = 0;
  localparam int unsigned EV_SRC_OVF = 1;
  localparam int unsigned EV_DST_OVF = 2;
  localparam int unsigned EV_XFER_END = 3;

  localparam logic [MODE_W-1:0] MODE_RST = 16'h0000;
  localparam logic [EV_W-1:0] STAT_RST = 4'h0;
  localparam logic [EV_W-1:0] MASK_RST = 4'h0;

  localparam logic [1:0] XM_AUTO_STEAL = 2'h0;
  localparam logic [1:0] XM_AUTO_BURST = 2'h1;
  localparam logic [1:0] XM_EXT_STEAL = 2'h2;
  localparam logic [1:0] XM_EXT_BLOCK = 2'h3;

  typedef enum logic {ST_IDLE, ST_XFER} dcmc_state_type;

  typedef struct packed {
    logic single_addr;
    logic ext_request;
    logic burst;
    logic block;
    logic dir_to_dest;
  } dcmc_mode_type;

  typedef struct packed {
    logic xfer_end;
    logic dst_ovf;
    logic src_ovf;
    logic count_end;
  } dcmc_event_type;

endpackage

//--- core/dcmc_req_sense.sv
// Purpose: samples the external request pin by level or falling edge
// Assumes: pin synchronous to mclk, active low
// Notes: first request after enable is always level sensed
`timescale 1ns/1ps
`default_nettype none
module dcmc_req_sense (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic enable,
  input wire logic edge_sel,
  input wire logic req_pin_n,
  input wire logic consume,
  output logic pending
);
  import dcmc_pkg::*;

  logic pin_prev_q;
  logic edge_q;
  logic first_q;
  logic level_mode;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pin_prev_q <= 1'b1;
    end else begin
      pin_prev_q <= req_pin_n;
    end
  end

  // falling edge latched; the level-sensed first start swallows it
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      edge_q <= 1'b0;
    end else if (!enable) begin
      edge_q <= 1'b0;
    end else if (consume && first_q) begin
      edge_q <= 1'b0;
    end else if (pin_prev_q && !req_pin_n) begin
      edge_q <= 1'b1;
    end else if (consume) begin
      edge_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      first_q <= 1'b1;
    end else if (!enable) begin
      first_q <= 1'b1;
    end else if (consume) begin
      first_q <= 1'b0;
    end
  end

  assign level_mode = !edge_sel || first_q;
  assign pending = enable && (level_mode ? !req_pin_n : edge_q);

  first_level_a: assert property (@(posedge mclk) disable iff (!nrst)
    (enable && first_q && !req_pin_n) |-> pending)
    else $error("first request after enable not level sensed");

endmodule // dcmc_req_sense
`default_nettype wire

//--- core/dcmc_irq_stat.sv
// Purpose: sticky event status, mask and the block interrupt line
// Assumes: clear by writing one to a status bit
// Notes: an event in the clearing cycle stays set
`timescale 1ns/1ps
`default_nettype none
module dcmc_irq_stat (
  input wire logic mclk,
  input wire logic nrst,
  input wire dcmc_pkg::dcmc_event_type events,
  input wire logic clr_wr,
  input wire logic mask_wr,
  input wire logic [dcmc_pkg::EV_W-1:0] wdata,
  output logic [dcmc_pkg::EV_W-1:0] status,
  output logic [dcmc_pkg::EV_W-1:0] mask,
  output logic irq
);
  import dcmc_pkg::*;

  logic [EV_W-1:0] status_q;
  logic [EV_W-1:0] mask_q;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      status_q <= STAT_RST;
    end else begin
      status_q <= (status_q & ~(clr_wr ? wdata : STAT_RST)) | events;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      mask_q <= MASK_RST;
    end else if (mask_wr) begin
      mask_q <= wdata;
    end
  end

  assign status = status_q;
  assign mask = mask_q;
  assign irq = |(status_q & mask_q);

  sticky_set_a: assert property (@(posedge mclk) disable iff (!nrst)
    (|events) |=> ((status_q & $past(events)) == $past(events)))
    else $error("event lost from status");

endmodule // dcmc_irq_stat
`default_nettype wire

//--- core/dcmc_channel.sv
// Purpose: mode control, transfer-end flag and request/acknowledge for one dma channel
// Assumes: apb slave with zero wait states, engine reports count end, overflows, cycle done
// Notes: mode register at MODE_OFS, event status at STAT_OFS, event mask at MASK_OFS
`timescale 1ns/1ps
`default_nettype none
module dcmc_channel (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [dcmc_pkg::ADDR_W-1:0] paddr,
  input wire logic [dcmc_pkg::DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [dcmc_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic xfer_request_pin_n,
  output logic xfer_ack_pin_n,
  input wire logic count_end,
  input wire logic src_repeat_ovf,
  input wire logic dst_repeat_ovf,
  input wire logic xfer_done,
  output logic xfer_start,
  output var dcmc_pkg::dcmc_mode_type mode_o,
  output logic channel_active,
  output logic channel_irq,
  output logic irq
);
  import dcmc_pkg::*;

  // register state
  logic active_q;
  logic req_sense_q;
  logic ams_q;
  logic [1:0] xfer_mode_q;
  logic irq_en_q;
  logic flag_q;
  logic flag_d;
  logic tce_en_q;
  logic single_addr_direction_q;
  logic flag_seen_q;
  logic [DATA_W-1:0] prdata_q;
  dcmc_state_type state_q;
  dcmc_state_type state_d;

  // bus decode
  logic setup;
  logic access;
  logic wr;
  logic rd;
  logic mode_hit;
  logic stat_hit;
  logic mask_hit;
  logic mapped;
  logic mode_wr_lo;
  logic mode_wr_hi;

  // flag control
  logic flag_set;
  logic flag_clr_sw;
  logic flag_clr_act;
  logic active_prev_q;

  // transfer control
  logic ext_mode;
  logic req_pending;
  logic go;

  // event status
  dcmc_event_type events;
  logic [EV_W-1:0] ev_status;
  logic [EV_W-1:0] ev_mask;

  function automatic logic [MODE_W-1:0] mode_word(
    input logic act,
    input logic rs,
    input logic am,
    input logic [1:0] xm,
    input logic ie,
    input logic fl,
    input logic te,
    input logic sd
  );
    logic [MODE_W-1:0] w;
    w = MODE_RST;
    w[BIT_ACTIVE] = act;
    w[BIT_REQ_SENSE] = rs;
    w[BIT_AMS] = am;
    w[BIT_MODE_HI:BIT_MODE_LO] = xm;
    w[BIT_IRQ_EN] = ie;
    w[BIT_IRQ_FLAG] = fl;
    w[BIT_TCE_EN] = te;
    w[BIT_SINGLE_ADDR_DIRECTION] = sd;
    return w;
  endfunction

  assign setup = psel && !penable;
  assign access = psel && penable;
  assign wr = access && pwrite;
  assign rd = access && !pwrite;
  assign mode_hit = paddr == MODE_OFS;
  assign stat_hit = paddr == STAT_OFS;
  assign mask_hit = paddr == MASK_OFS;
  assign mapped = mode_hit || stat_hit || mask_hit;
  assign mode_wr_lo = wr && mode_hit && pstrb[0];
  assign mode_wr_hi = wr && mode_hit && pstrb[1];

  // zero wait states: read data captured in setup, answer in access
  assign pready = access;
  assign pslverr = access && !mapped;
  assign prdata = prdata_q;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      prdata_q <= 32'h00000000;
    end else if (setup && !pwrite) begin
      if (mode_hit) begin
        prdata_q <= {16'h0000, mode_word(active_q, req_sense_q, ams_q, xfer_mode_q,
                                         irq_en_q, flag_q, tce_en_q, single_addr_direction_q)};
      end else if (stat_hit) begin
        prdata_q <= {28'h0000000, ev_status};
      end else if (mask_hit) begin
        prdata_q <= {28'h0000000, ev_mask};
      end else begin
        prdata_q <= 32'h00000000;
      end
    end
  end

  // plain read/write mode fields, high byte
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      req_sense_q <= MODE_RST[BIT_REQ_SENSE];
      ams_q <= MODE_RST[BIT_AMS];
      xfer_mode_q <= MODE_RST[BIT_MODE_HI:BIT_MODE_LO];
    end else if (mode_wr_hi) begin
      req_sense_q <= pwdata[BIT_REQ_SENSE];
      ams_q <= pwdata[BIT_AMS];
      xfer_mode_q <= pwdata[BIT_MODE_HI:BIT_MODE_LO];
    end
  end

  // plain read/write mode fields, low byte
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      irq_en_q <= MODE_RST[BIT_IRQ_EN];
      tce_en_q <= MODE_RST[BIT_TCE_EN];
      single_addr_direction_q <= MODE_RST[BIT_SINGLE_ADDR_DIRECTION];
    end else if (mode_wr_lo) begin
      irq_en_q <= pwdata[BIT_IRQ_EN];
      tce_en_q <= pwdata[BIT_TCE_EN];
      single_addr_direction_q <= pwdata[BIT_SINGLE_ADDR_DIRECTION];
    end
  end

  // flag sources and clears
  assign flag_set = (count_end && tce_en_q) || src_repeat_ovf || dst_repeat_ovf;
  assign flag_clr_act = mode_wr_hi && pwdata[BIT_ACTIVE];
  assign flag_clr_sw = mode_wr_lo && !pwdata[BIT_IRQ_FLAG] && flag_seen_q;

  always_comb begin
    flag_d = flag_q;
    if (flag_clr_sw || flag_clr_act) begin
      flag_d = 1'b0;
    end
    if (flag_set) begin
      flag_d = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      flag_q <= MODE_RST[BIT_IRQ_FLAG];
    end else begin
      flag_q <= flag_d;
    end
  end

  // a zero write only clears once the one was read back
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      flag_seen_q <= 1'b0;
    end else if (!flag_d) begin
      flag_seen_q <= 1'b0;
    end else if (rd && mode_hit && prdata_q[BIT_IRQ_FLAG]) begin
      flag_seen_q <= 1'b1;
    end
  end

  // channel active: flag setting ends the transfer, winning over a start write
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      active_q <= MODE_RST[BIT_ACTIVE];
    end else if (flag_set || count_end) begin
      active_q <= 1'b0;
    end else if (mode_wr_hi) begin
      active_q <= pwdata[BIT_ACTIVE];
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      active_prev_q <= 1'b0;
    end else begin
      active_prev_q <= active_q;
    end
  end

  assign channel_active = active_q;
  assign channel_irq = irq_en_q && flag_q;

  // mode decode for the engine
  always_comb begin
    mode_o.single_addr = ams_q;
    mode_o.ext_request = xfer_mode_q[1];
    mode_o.burst = xfer_mode_q == XM_AUTO_BURST;
    mode_o.block = xfer_mode_q == XM_EXT_BLOCK;
    mode_o.dir_to_dest = ams_q && single_addr_direction_q;
  end

  // request sensing
  assign ext_mode = xfer_mode_q[1];

  dcmc_req_sense u_req_sense (
    .mclk(mclk),
    .nrst(nrst),
    .enable(active_q && ext_mode),
    .edge_sel(req_sense_q),
    .req_pin_n(xfer_request_pin_n),
    .consume(go),
    .pending(req_pending)
  );

  // transfer sequencing
  assign go = state_q == ST_IDLE && active_q && (ext_mode ? req_pending : 1'b1);

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: begin
        if (go) begin
          state_d = ST_XFER;
        end
      end
      ST_XFER: begin
        if (xfer_done) begin
          state_d = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  assign xfer_start = go;
  assign xfer_ack_pin_n = !(state_q == ST_XFER && ams_q);

  // event status and block interrupt
  always_comb begin
    events.count_end = count_end;
    events.src_ovf = src_repeat_ovf;
    events.dst_ovf = dst_repeat_ovf;
    events.xfer_end = active_prev_q && !active_q;
  end

  dcmc_irq_stat u_irq_stat (
    .mclk(mclk),
    .nrst(nrst),
    .events(events),
    .clr_wr(wr && stat_hit && pstrb[0]),
    .mask_wr(wr && mask_hit && pstrb[0]),
    .wdata(pwdata[EV_W-1:0]),
    .status(ev_status),
    .mask(ev_mask),
    .irq(irq)
  );

  // checks
  ams_decode_a: assert property (@(posedge mclk) disable iff (!nrst)
    mode_wr_hi |=> mode_o.single_addr == $past(pwdata[BIT_AMS]))
    else $error("address mode field not decoded");

  ack_dual_a: assert property (@(posedge mclk) disable iff (!nrst)
    !mode_o.single_addr |-> xfer_ack_pin_n)
    else $error("acknowledge driven in dual addressing");

  mode_burst_a: assert property (@(posedge mclk) disable iff (!nrst)
    mode_o.burst |-> !mode_o.ext_request && !mode_o.block)
    else $error("burst decoded with external request");

  irq_raise_a: assert property (@(posedge mclk) disable iff (!nrst)
    (flag_set && irq_en_q && !mode_wr_lo) |=> channel_irq)
    else $error("channel interrupt not raised");

  irq_drop_a: assert property (@(posedge mclk) disable iff (!nrst)
    ($fell(irq_en_q) || $fell(flag_q)) |-> !channel_irq)
    else $error("channel interrupt not withdrawn");

  ovf_flag_a: assert property (@(posedge mclk) disable iff (!nrst)
    (src_repeat_ovf || dst_repeat_ovf) |=> flag_q && !active_q)
    else $error("overflow did not set flag");

  end_xfer_a: assert property (@(posedge mclk) disable iff (!nrst)
    flag_set |=> !active_q && !xfer_start)
    else $error("flag set while channel stays active");

  act_clear_a: assert property (@(posedge mclk) disable iff (!nrst)
    (flag_clr_act && !flag_set) |=> !flag_q)
    else $error("active write did not clear flag");

  unread_clr_a: assert property (@(posedge mclk) disable iff (!nrst)
    (flag_q && !flag_seen_q && !flag_clr_act) |=> flag_q)
    else $error("flag cleared without prior read");

  seen_clear_a: assert property (@(posedge mclk) disable iff (!nrst)
    (flag_q && flag_seen_q && mode_wr_lo && !pwdata[BIT_IRQ_FLAG] && !flag_set) |=> !flag_q)
    else $error("read flag not cleared by zero write");

  one_write_a: assert property (@(posedge mclk) disable iff (!nrst)
    (!flag_q && !flag_set) |=> !flag_q)
    else $error("flag set by a write");

  tce_gate_a: assert property (@(posedge mclk) disable iff (!nrst)
    (count_end && !tce_en_q && !src_repeat_ovf && !dst_repeat_ovf && !flag_q) |=> !flag_q)
    else $error("count end set flag while disabled");

  dir_path_a: assert property (@(posedge mclk) disable iff (!nrst)
    mode_o.dir_to_dest == (single_addr_direction_q && mode_o.single_addr))
    else $error("direction not gated by addressing mode");

  pending_a: assert property (@(posedge mclk) disable iff (!nrst)
    (flag_q && !irq_en_q && mode_wr_lo && pwdata[BIT_IRQ_EN] && pwdata[BIT_IRQ_FLAG] && !flag_clr_act)
    |=> channel_irq)
    else $error("pending flag lost");

endmodule // dcmc_channel
`default_nettype wire

//--- verif/dcmc_periph.sv
// Purpose: external peripheral on the request pin, started by the transfer start strobe
// Assumes: request pin held low while want is high, synchronous to mclk
// Notes: reports the end of each transfer cycle, promptly or slowly
`timescale 1ns/1ps
`default_nettype none
module dcmc_periph (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic want,
  input wire logic slow,
  input wire logic start,
  output logic req_n,
  output logic done
);
  logic [2:0] cnt_q;
  logic busy_q;
  // active low request, level held as long as asked
  assign req_n = ~want;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      busy_q <= 1'b0;
      cnt_q <= 3'h0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        busy_q <= 1'b1;
        cnt_q <= slow ? 3'h4 : 3'h0;
      end else if (busy_q && cnt_q != 3'h0) begin
        cnt_q <= cnt_q - 3'h1;
      end else if (busy_q) begin
        busy_q <= 1'b0;
        done <= 1'b1;
      end
    end
  end
endmodule // dcmc_periph
`default_nettype wire

//--- verif/tb_top.sv
// Purpose: self-checking bench for the channel mode control block
// Assumes: zero wait apb slave, peripheral model on the request pins
// Notes: random mode values from an lfsr seeded with 32'h4099
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import dcmc_pkg::*;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0;
  logic [3:0] pstrb = 4'hF;
  logic cend = 1'b0, sovf = 1'b0, dovf = 1'b0, want = 1'b0, slow = 1'b0;
  logic [DATA_W-1:0] prdata;
  logic pready, pslverr, req_n, ack_n, xstart, xdone, act, chirq, irq, err_seen;
  dcmc_mode_type mode;
  logic [31:0] lf = 32'h4099;
  logic [31:0] rd;
  logic [15:0] d;
  int num_errors = 0, checks_done = 0, n_start = 0, n_ack = 0, ack_bad = 0;

  always #10 mclk = ~mclk;

  dcmc_channel DUT (.mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .xfer_request_pin_n(req_n), .xfer_ack_pin_n(ack_n), .count_end(cend),
    .src_repeat_ovf(sovf), .dst_repeat_ovf(dovf), .xfer_done(xdone), .xfer_start(xstart),
    .mode_o(mode), .channel_active(act), .channel_irq(chirq), .irq(irq));

  dcmc_periph peer (.mclk(mclk), .nrst(nrst), .want(want), .slow(slow), .start(xstart),
    .req_n(req_n), .done(xdone));

  always @(posedge mclk) begin
    if (xstart === 1'b1) n_start++;
    if (ack_n === 1'b0) n_ack++;
    if (ack_n === 1'b0 && mode.single_addr !== 1'b1) ack_bad++;
  end

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one transfer, then an idle cycle so the next setup never collides
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] wd);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      num_errors++;
      end_sim();
    end
    rd = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic pulse(input int k);
    cend <= (k == 0);
    sovf <= (k == 1);
    dovf <= (k == 2);
    @(posedge mclk);
    cend <= 1'b0;
    sovf <= 1'b0;
    dovf <= 1'b0;
    @(posedge mclk);
  endtask

  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  function automatic logic [4:0] mode_exp(input logic [15:0] m);
    return {m[10], m[9], m[9:8] == 2'h1, m[9:8] == 2'h3, m[10] & m[4]};
  endfunction

  task automatic rd_mode(input string what, input logic [31:0] exp);
    apb(1'b0, MODE_OFS, 32'h0);
    check(what, rd, exp);
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    num_errors++;
    end_sim();
  end

  initial begin
    repeat (8) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    rd_mode("mode reset", 32'h0);
    apb(1'b0, STAT_OFS, 32'h0);
    check("status reset", rd, 32'h0);
    apb(1'b0, MASK_OFS, 32'h0);
    check("mask reset", rd, 32'h0);
    apb(1'b0, 12'h00C, 32'h0);
    check("unmapped err", {31'h0, err_seen}, 32'h1);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      lf = lfsr(lf);
      d = lf[15:0] & 16'h7FFF;
      d[9:8] = i[1:0];
      apb(1'b1, MODE_OFS, {16'h0, d});
      rd_mode("mode readback", {16'h0, d & 16'h0FB0});
      check("mode fields", {27'h0, mode}, {27'h0, mode_exp(d)});
    end
    $display("test mode fields done");
    n_start = 0;
    n_ack = 0;
    slow <= lf[0];
    apb(1'b1, MODE_OFS, 32'h8610);
    want <= 1'b1;
    repeat (40) @(posedge mclk);
    want <= 1'b0;
    repeat (8) @(posedge mclk);
    check("level starts", {31'h0, n_start >= 4}, 32'h1);
    check("ack seen", {31'h0, n_ack > 0}, 32'h1);
    apb(1'b1, MODE_OFS, 32'h0E10);
    apb(1'b1, MODE_OFS, 32'h8E10);
    n_start = 0;
    want <= 1'b1;
    repeat (30) @(posedge mclk);
    check("edge first", n_start, 32'h1);
    want <= 1'b0;
    repeat (3) @(posedge mclk);
    want <= 1'b1;
    repeat (20) @(posedge mclk);
    check("edge second", n_start, 32'h2);
    want <= 1'b0;
    apb(1'b1, MODE_OFS, 32'h0E10);
    n_start = 0;
    slow <= lf[1];
    apb(1'b1, MODE_OFS, 32'h8110);
    repeat (20) @(posedge mclk);
    apb(1'b1, MODE_OFS, 32'h0110);
    check("auto starts", {31'h0, n_start > 0}, 32'h1);
    $display("test transfers done");
    apb(1'b1, MODE_OFS, 32'h8000);
    repeat (4) @(posedge mclk);
    pulse(1);
    check("active ends", {31'h0, act}, 32'h0);
    rd_mode("flag src", 32'h0040);
    check("pending irq", {31'h0, chirq}, 32'h0);
    apb(1'b1, MODE_OFS, 32'h00C0);
    check("irq raised", {31'h0, chirq}, 32'h1);
    rd_mode("flag kept", 32'h00C0);
    apb(1'b1, MODE_OFS, 32'h0080);
    check("irq flag clr", {31'h0, chirq}, 32'h0);
    rd_mode("flag cleared", 32'h0080);
    pulse(0);
    rd_mode("count end off", 32'h0080);
    apb(1'b1, MODE_OFS, 32'h00A0);
    pulse(0);
    check("count end irq", {31'h0, chirq}, 32'h1);
    apb(1'b1, MODE_OFS, 32'h0060);
    check("irq en clr", {31'h0, chirq}, 32'h0);
    apb(1'b1, MODE_OFS, 32'h8040);
    rd_mode("active clears", 32'h8000);
    pulse(2);
    apb(1'b1, MODE_OFS, 32'h0000);
    rd_mode("flag dst", 32'h0040);
    apb(1'b1, MODE_OFS, 32'h0000);
    rd_mode("flag zero", 32'h0000);
    $display("test flag done");
    apb(1'b1, STAT_OFS, 32'hF);
    apb(1'b1, MASK_OFS, 32'h1);
    pulse(0);
    check("event irq", {31'h0, irq}, 32'h1);
    apb(1'b1, MASK_OFS, 32'h0);
    check("masked irq", {31'h0, irq}, 32'h0);
    apb(1'b1, MASK_OFS, 32'h1);
    check("unmasked irq", {31'h0, irq}, 32'h1);
    apb(1'b1, STAT_OFS, 32'h1);
    check("cleared irq", {31'h0, irq}, 32'h0);
    pulse(1);
    pulse(2);
    apb(1'b0, STAT_OFS, 32'h0);
    check("ovf status", rd & 32'h7, 32'h6);
    apb(1'b0, MASK_OFS, 32'h0);
    check("mask read", rd, 32'h1);
    check("dual no ack", ack_bad, 32'h0);
    $display("test events done");
    end_sim();
  end
endmodule // tb_top
`default_nettype wire
